//--- include/pri_pkg.sv
// Constants, field layout and types for the register init and protection block
// Functional notes
// - Hold a reprogrammable 64-bit user signature store
// - Signature is readable whatever the protection state
// - Protected device refuses configuration array readback
// - Protection clears only through a full reprogramming; presetn also clears it here
// - Programming cycle erases the array automatically
// - Preload forces each output register high or low
// - Power-up reset drives all registers low, 1us
// - Output pins show polarity applied to low state
package pri_pkg;

   // ****************************************************************
   // Widths and sizes
   // ****************************************************************
   localparam int ADDR_W = 8;          // APB byte address width
   localparam int DATA_W = 32;         // APB data width
   localparam int SIG_W = 64;          // User signature width
   localparam int NOUT = 12;           // Registered outputs
   localparam int NCFG = 8;            // Configuration array words

   // ****************************************************************
   // Register byte addresses
   // ****************************************************************
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;     // Mode and commands
   localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;     // Block state
   localparam logic [ADDR_W-1:0] ADDR_SIG_LO = 8'h08;   // Signature bits 31:0
   localparam logic [ADDR_W-1:0] ADDR_SIG_HI = 8'h0c;   // Signature bits 63:32
   localparam logic [ADDR_W-1:0] ADDR_CFG_IDX = 8'h10;  // Array word index
   localparam logic [ADDR_W-1:0] ADDR_CFG_DATA = 8'h14; // Array word data
   localparam logic [ADDR_W-1:0] ADDR_PRELOAD = 8'h18;  // Preload value, write forces in programming mode

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_PROG_BIT = 0;    // Programming or test mode
   localparam int CTRL_SECURE_BIT = 1;  // Write one: program protection cell
   localparam int CTRL_START_BIT = 2;   // Write one: start programming cycle
   localparam int STAT_PROT_BIT = 0;    // Protection cell programmed
   localparam int STAT_BUSY_BIT = 1;    // Programming cycle running
   localparam int STAT_POR_BIT = 2;     // Power-up reset time elapsed
   localparam int STAT_MODE_BIT = 3;    // Mirror of programming mode
   localparam int STAT_Q_LSB = 16;      // Output register state
   localparam int CFG0_POL_LSB = 0;     // Word 0: output polarity
   localparam int CFG0_OE_LSB = 16;     // Word 0: output enables

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [SIG_W-1:0] SIG_RST = 64'h0;
   localparam logic [DATA_W-1:0] CFG_RST = 32'h0;
   localparam logic PROG_RST = 1'b0;
   localparam logic PROT_RST = 1'b0;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;                 // pclk at 100 MHz
   localparam int T_PR_NS = 1000;                     // Power-up reset, longest
   localparam int PR_CYC = T_PR_NS / CLK_PERIOD_NS;   // Rounded down
   localparam int POR_CNT_W = 7;                      // Holds PR_CYC - 1

   // ****************************************************************
   // Programming sequencer states, Gray from idle through erase to unlock
   // ****************************************************************
   typedef enum logic [1:0] {
      PRI_IDLE = 2'b00,
      PRI_ERASE = 2'b01,
      PRI_UNLOCK = 2'b11
   } pri_seq_t;

endpackage

//--- design/pri_sig_store.sv
// User signature store, two 32-bit words written by lane
`timescale 1ns/10ps
module pri_sig_store
   import pri_pkg::*;
#(
   parameter int NWORD = pri_pkg::SIG_W / pri_pkg::DATA_W
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [NWORD-1:0] we,
   input wire logic [pri_pkg::DATA_W-1:0] wdata,
   output logic [pri_pkg::SIG_W-1:0] sig
);

   // ****************************************************************
   // Storage, one flop word per lane
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NWORD; g++)
      begin : g_word
         // Content is entirely the user's; no field has meaning here
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               sig[g*DATA_W +: DATA_W] <= SIG_RST[g*DATA_W +: DATA_W];
            else if (we[g])
               sig[g*DATA_W +: DATA_W] <= wdata;
         end

         // A lane write lands in its own word on the next edge
         property p_sig_word;
            @(posedge pclk) disable iff (!presetn)
            we[g] |=> sig[g*DATA_W +: DATA_W] == $past(wdata);
         endproperty
         a_sig_word: assert property (p_sig_word) else $error("signature word not written");
      end
   endgenerate

endmodule // pri_sig_store

//--- design/pri_olmc.sv
// Registered output cells with power-up hold, preload and polarity
`timescale 1ns/10ps
module pri_olmc
   import pri_pkg::*;
#(
   parameter int NOUT = pri_pkg::NOUT
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hold,
   input wire logic pre_go,
   input wire logic [NOUT-1:0] pre_val,
   input wire logic [NOUT-1:0] d_in,
   input wire logic [NOUT-1:0] pol,
   input wire logic [NOUT-1:0] oe,
   output logic [NOUT-1:0] pin_out,
   output logic [NOUT-1:0] pin_oe,
   output logic [NOUT-1:0] q
);

   // ****************************************************************
   // Per-output register, pin and enable
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NOUT; g++)
      begin : g_cell
         logic q_nxt; // Next register state

         // Hold beats preload, preload beats the array's next state
         assign q_nxt = hold ? 1'b0 : (pre_go ? pre_val[g] : d_in[g]);

         // Pin flop carries the polarity so the pin needs no gate after it
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               q[g] <= 1'b0;
               pin_out[g] <= 1'b0;
               pin_oe[g] <= 1'b0;
            end
            else
            begin
               q[g] <= q_nxt;
               pin_out[g] <= q_nxt ^ pol[g];
               pin_oe[g] <= oe[g];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_preload;
      @(posedge pclk) disable iff (!presetn)
      pre_go && !hold |=> q == $past(pre_val) && pin_out == ($past(pre_val) ^ $past(pol));
   endproperty
   a_preload: assert property (p_preload) else $error("preload value not forced");

   property p_pol_low;
      @(posedge pclk) disable iff (!presetn)
      hold |=> q == '0 && pin_out == $past(pol);
   endproperty
   a_pol_low: assert property (p_pol_low) else $error("pin not polarity of low state");

endmodule // pri_olmc

//--- design/pri_top.sv
// APB register file, protection cell, programming sequencer and power-up reset
`timescale 1ns/10ps
module pri_top
   import pri_pkg::*;
#(
   parameter int NOUT = pri_pkg::NOUT,
   parameter int NCFG = pri_pkg::NCFG
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pri_pkg::ADDR_W-1:0] paddr,
   input wire logic [pri_pkg::DATA_W-1:0] pwdata,
   output logic [pri_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NOUT-1:0] d_in,
   output logic [NOUT-1:0] pin_out,
   output logic [NOUT-1:0] pin_oe
);
   import pri_pkg::*;

   localparam int IDX_W = $clog2(NCFG); // Array index width

   // ****************************************************************
   // State
   // ****************************************************************
   logic prog_r;                         // Programming or test mode
   logic prot_r;                         // Protection cell
   pri_seq_t seq_r;                      // Programming sequencer
   logic [IDX_W-1:0] era_idx_r;          // Word under erase
   logic [IDX_W-1:0] cfg_idx_r;          // Software array index
   logic [DATA_W-1:0] cfg_mem_r [NCFG];  // Configuration array
   logic [POR_CNT_W-1:0] por_cnt_r;      // Power-up reset timer
   logic por_done_r;                     // Power-up time elapsed
   logic pre_go_r;                       // One-cycle preload strobe
   logic [NOUT-1:0] pre_val_r;           // Value to force
   logic [SIG_W-1:0] sig;                // Signature content
   logic [NOUT-1:0] q;                   // Output register state

   // ****************************************************************
   // APB decode
   // ****************************************************************
   logic acc_first;   // First access cycle, answer prepared here
   logic acc_done;    // Completing edge of a transfer
   logic wr_en;       // Write takes effect
   logic hit_ctrl;
   logic hit_stat;
   logic hit_sig_lo;
   logic hit_sig_hi;
   logic hit_idx;
   logic hit_data;
   logic hit_pre;
   logic mapped;
   logic busy;
   logic rd_blocked;
   logic rd_err;
   logic [DATA_W-1:0] stat_word;
   logic [DATA_W-1:0] rd_data;

   assign acc_first = psel & penable & ~pready;
   assign acc_done = psel & penable & pready;
   assign wr_en = acc_done & pwrite;
   assign hit_ctrl = paddr == ADDR_CTRL;
   assign hit_stat = paddr == ADDR_STAT;
   assign hit_sig_lo = paddr == ADDR_SIG_LO;
   assign hit_sig_hi = paddr == ADDR_SIG_HI;
   assign hit_idx = paddr == ADDR_CFG_IDX;
   assign hit_data = paddr == ADDR_CFG_DATA;
   assign hit_pre = paddr == ADDR_PRELOAD;
   assign mapped = hit_ctrl | hit_stat | hit_sig_lo | hit_sig_hi | hit_idx | hit_data | hit_pre;
   assign busy = seq_r != PRI_IDLE;

   // Array readback is refused once protected; the answer carries no data
   assign rd_blocked = hit_data & ~pwrite & prot_r;
   assign rd_err = ~mapped | rd_blocked;

   assign stat_word = (DATA_W'(q) << STAT_Q_LSB)
                    | (DATA_W'(prog_r) << STAT_MODE_BIT)
                    | (DATA_W'(por_done_r) << STAT_POR_BIT)
                    | (DATA_W'(busy) << STAT_BUSY_BIT)
                    | (DATA_W'(prot_r) << STAT_PROT_BIT);

   // Signature words sit outside the protection gate on purpose
   assign rd_data = hit_ctrl ? DATA_W'(prog_r) << CTRL_PROG_BIT
                  : hit_stat ? stat_word
                  : hit_sig_lo ? sig[DATA_W-1:0]
                  : hit_sig_hi ? sig[SIG_W-1:DATA_W]
                  : hit_idx ? DATA_W'(cfg_idx_r)
                  : (hit_data & ~prot_r) ? cfg_mem_r[cfg_idx_r]
                  : '0;

   // ****************************************************************
   // Commands and array writes gated by mode and by the sequencer; signature writes by mode only
   // ****************************************************************
   logic ctrl_wr;
   logic secure_cmd;
   logic start_cmd;
   logic cfg_we;
   logic [1:0] sig_we;

   assign ctrl_wr = wr_en & hit_ctrl;
   // Mode taken from before the write, so one write cannot enter and act
   assign secure_cmd = ctrl_wr & pwdata[CTRL_SECURE_BIT] & prog_r & ~busy;
   assign start_cmd = ctrl_wr & pwdata[CTRL_START_BIT] & prog_r & ~busy;
   // Software writes change array words only between programming cycles, in programming mode
   assign cfg_we = wr_en & hit_data & prog_r & ~busy;
   assign sig_we = {wr_en & hit_sig_hi & prog_r, wr_en & hit_sig_lo & prog_r};

   // ****************************************************************
   // APB answer, one wait state
   // ****************************************************************
   // pready rises in the second access cycle; data and error ride with it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= acc_first;
         pslverr <= acc_first & rd_err;
         prdata <= (acc_first & ~pwrite) ? rd_data : '0;
      end
   end

   // ****************************************************************
   // Mode, index and preload registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prog_r <= PROG_RST;
         cfg_idx_r <= '0;
         pre_val_r <= '0;
         pre_go_r <= 1'b0;
      end
      else
      begin
         if (ctrl_wr)
            prog_r <= pwdata[CTRL_PROG_BIT];
         if (wr_en & hit_idx)
            cfg_idx_r <= pwdata[IDX_W-1:0];
         if (wr_en & hit_pre)
            pre_val_r <= pwdata[NOUT-1:0];
         // Outside programming mode a preload write only stores the value
         pre_go_r <= wr_en & hit_pre & prog_r;
      end
   end

   // ****************************************************************
   // Protection cell
   // ****************************************************************
   // No software path clears it; only presetn and the end of a programming cycle do
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prot_r <= PROT_RST;
      else if (seq_r == PRI_UNLOCK)
         prot_r <= 1'b0;
      else if (secure_cmd)
         prot_r <= 1'b1;
   end

   // ****************************************************************
   // Programming sequencer: erase every word, then unlock
   // ****************************************************************
   // Erase is part of the cycle itself; the programmer never asks for it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         seq_r <= PRI_IDLE;
         era_idx_r <= '0;
      end
      else
      begin
         unique case (seq_r)
            PRI_IDLE:
            begin
               era_idx_r <= '0;
               if (start_cmd)
                  seq_r <= PRI_ERASE;
            end
            PRI_ERASE:
            begin
               era_idx_r <= era_idx_r + 1'b1;
               if (era_idx_r == IDX_W'(NCFG - 1))
                  seq_r <= PRI_UNLOCK;
            end
            PRI_UNLOCK:
               seq_r <= PRI_IDLE;
            default:
               seq_r <= PRI_IDLE; // Code 2'b10 is illegal
         endcase
      end
   end

   // ****************************************************************
   // Configuration array
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < NCFG; g++)
      begin : g_cfg
         // Erase wins; software writes are refused while busy anyway
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               cfg_mem_r[g] <= CFG_RST;
            else if (seq_r == PRI_ERASE && era_idx_r == IDX_W'(g))
               cfg_mem_r[g] <= '0;
            else if (cfg_we && cfg_idx_r == IDX_W'(g))
               cfg_mem_r[g] <= pwdata;
         end
      end
   endgenerate

   // ****************************************************************
   // Power-up reset timer
   // ****************************************************************
   // Registers are low from the reset itself; the timer bounds the hold
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         por_cnt_r <= '0;
         por_done_r <= 1'b0;
      end
      else if (!por_done_r)
      begin
         por_cnt_r <= por_cnt_r + 1'b1;
         por_done_r <= por_cnt_r == POR_CNT_W'(PR_CYC - 1);
      end
   end

   // ****************************************************************
   // Submodules
   // ****************************************************************
   pri_sig_store u_sig (
      .pclk(pclk),
      .presetn(presetn),
      .we(sig_we),
      .wdata(pwdata),
      .sig(sig)
   );

   // Polarity and enables live in array word 0, readable or not
   pri_olmc #(.NOUT(NOUT)) u_olmc (
      .pclk(pclk),
      .presetn(presetn),
      .hold(~por_done_r),
      .pre_go(pre_go_r),
      .pre_val(pre_val_r),
      .d_in(d_in),
      .pol(cfg_mem_r[0][CFG0_POL_LSB +: NOUT]),
      .oe(cfg_mem_r[0][CFG0_OE_LSB +: NOUT]),
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .q(q)
   );

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic mem_any; // Any array bit set, for the erase check

   always_comb
   begin
      mem_any = 1'b0;
      for (int i = 0; i < NCFG; i++)
         mem_any = mem_any | (|cfg_mem_r[i]);
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_sig_read;
      acc_first && !pwrite && hit_sig_hi |=> pready && !pslverr && prdata == sig[SIG_W-1:DATA_W];
   endproperty
   a_sig_read: assert property (p_sig_read) else $error("signature read refused");

   property p_prot_refuse;
      acc_first && !pwrite && hit_data && prot_r |=> pready && pslverr && prdata == '0;
   endproperty
   a_prot_refuse: assert property (p_prot_refuse) else $error("protected readback leaked");

   property p_prot_clear;
      $fell(prot_r) |-> $past(seq_r) == PRI_UNLOCK && $past(seq_r, 2) == PRI_ERASE;
   endproperty
   a_prot_clear: assert property (p_prot_clear) else $error("protection cleared early");

   property p_erase_auto;
      start_cmd |=> seq_r == PRI_ERASE ##1 seq_r == PRI_ERASE;
   endproperty
   a_erase_auto: assert property (p_erase_auto) else $error("program cycle did not erase");

   property p_erased;
      seq_r == PRI_UNLOCK |-> !mem_any ##1 !prot_r;
   endproperty
   a_erased: assert property (p_erased) else $error("array not blank before unlock");

   property p_por_time;
      $rose(por_done_r) |-> $past(por_cnt_r) == POR_CNT_W'(PR_CYC - 1);
   endproperty
   a_por_time: assert property (p_por_time) else $error("power-up hold length wrong");

   property p_por_low;
      !por_done_r |-> q == '0;
   endproperty
   a_por_low: assert property (p_por_low) else $error("register not low at power-up");

   property p_preload_mode;
      pre_go_r |-> $past(prog_r) && $past(wr_en) && $past(hit_pre);
   endproperty
   a_preload_mode: assert property (p_preload_mode) else $error("preload outside prog mode");

endmodule // pri_top

//--- tb/pri_sys_model.sv
// System-side model that feeds next-state values into the output registers
`timescale 1ns/10ps
module pri_sys_model
   import pri_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [pri_pkg::NOUT-1:0] want,
   output logic [pri_pkg::NOUT-1:0] d_in
);
   // Static nonzero level while reset is low, so the hold is visible
   // Changes only just after an edge, so setup is met at the next one
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         d_in <= 12'ha5a;   // Power-up pattern
      else
         d_in <= want;      // Next state asked for by the bench
   end
endmodule // pri_sys_model

//--- tb/testbench.sv
// Self-checking bench for the register init and protection block
`timescale 1ns/10ps
module testbench;
   import pri_pkg::*;
   logic pclk = 1'b0;         // 100 MHz clock
   logic presetn = 1'b0;      // Active-low reset
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd, lo, hi, s3;
   logic pready, pslverr, er;
   logic [11:0] want = 12'h3c3; // Next state fed through the system model
   logic [11:0] d_in, pin_out, pin_oe, pol, oe, v;
   int seed = 32'hb631e492;   // Fixed seed, repeatable run
   int err_count = 0;
   int samples_checked = 0;
   int n;

   // ****************************************************************
   // Clock, design and far side
   // ****************************************************************
   always #5 pclk = ~pclk;
   pri_top pri_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .d_in(d_in), .pin_out(pin_out), .pin_oe(pin_oe));
   pri_sys_model pri_sys_model_inst (.pclk(pclk), .presetn(presetn), .want(want), .d_in(d_in));

   // ****************************************************************
   // Expectations, compare and bus tasks
   // ****************************************************************
   // Status word as laid out by the block, upper flags masked by callers
   function automatic logic [31:0] stat(input logic prot, busy, por, mode, input logic [11:0] q);
      return {4'h0, q, 12'h0, mode, por, busy, prot};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer; idle edge after it so no signal is driven twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         chk("pready wait", 32'h1, 32'h0);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Read with mask, compare data and error flag
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd & m);
      chk({what, " err"}, {31'h0, experr}, {31'h0, er});
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial
   begin
      #200000;
      err_count++;
      end_of_test();
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk("pin_out hold", 32'h0, {20'h0, pin_out});
      chk("pin_oe reset", 32'h0, {20'h0, pin_oe});
      @(posedge pclk);
      rchk("stat early", ADDR_STAT, 32'h0fff_000f, stat(1'b0, 1'b0, 1'b0, 1'b0, 12'h0), 1'b0);
      // Mid-hold, d_in already carries a nonzero next state
      #1 chk("pin_out held", 32'h0, {20'h0, pin_out});
      repeat (100) @(posedge pclk);
      rchk("stat por", ADDR_STAT, 32'h0fff_000f, stat(1'b0, 1'b0, 1'b1, 1'b0, want), 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h1);
      lo = $random(seed);
      hi = $random(seed);
      apb(1'b1, ADDR_SIG_LO, lo);
      apb(1'b1, ADDR_SIG_HI, hi);
      rchk("sig lo", ADDR_SIG_LO, 32'hffff_ffff, lo, 1'b0);
      rchk("sig hi", ADDR_SIG_HI, 32'hffff_ffff, hi, 1'b0);
      pol = 12'($random(seed));
      oe = 12'($random(seed));
      apb(1'b1, ADDR_CFG_IDX, 32'h0);
      apb(1'b1, ADDR_CFG_DATA, {4'h0, oe, 4'h0, pol});
      // Pin flops take word 0 on the edge the task returns on; look once settled
      #1 chk("pin_oe", {20'h0, oe}, {20'h0, pin_oe});
      chk("pin_out pol", {20'h0, want ^ pol}, {20'h0, pin_out});
      @(posedge pclk);
      // Preload corners first, then random states; d_in set opposite
      for (int i = 0; i < 4; i++)
      begin
         v = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
         want <= ~v;
         apb(1'b1, ADDR_PRELOAD, {20'h0, v});
         #1 chk("preload q", {20'h0, v ^ pol}, {20'h0, pin_out});
         @(posedge pclk);
         #1 chk("after preload", {20'h0, ~v ^ pol}, {20'h0, pin_out});
         @(posedge pclk);
      end
      // Outside programming mode preload writes force nothing and signature writes are dropped
      apb(1'b1, ADDR_CTRL, 32'h0);
      apb(1'b1, ADDR_PRELOAD, {20'h0, ~want});
      #1 chk("preload off", {20'h0, want ^ pol}, {20'h0, pin_out});
      @(posedge pclk);
      apb(1'b1, ADDR_SIG_HI, ~hi);
      rchk("sig kept", ADDR_SIG_HI, 32'hffff_ffff, hi, 1'b0);
      // Protection cell blocks array readback only
      s3 = $random(seed);
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b1, ADDR_CFG_IDX, 32'h3);
      apb(1'b1, ADDR_CFG_DATA, s3);
      rchk("cfg open", ADDR_CFG_DATA, 32'hffff_ffff, s3, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h3);
      rchk("prot set", ADDR_STAT, 32'h1, 32'h1, 1'b0);
      rchk("cfg locked", ADDR_CFG_DATA, 32'hffff_ffff, 32'h0, 1'b1);
      rchk("sig open", ADDR_SIG_LO, 32'hffff_ffff, lo, 1'b0);
      rchk("unmapped", 8'h1c, 32'hffff_ffff, 32'h0, 1'b1);
      // Programming cycle erases array and clears protection
      apb(1'b1, ADDR_CTRL, 32'h5);
      n = 0;
      do
      begin
         apb(1'b0, ADDR_STAT, 32'h0);
         n++;
      end
      while (rd[STAT_BUSY_BIT] === 1'b1 && n < 20);
      chk("busy end", 32'h0, {31'h0, rd[STAT_BUSY_BIT]});
      rchk("prot clear", ADDR_STAT, 32'h1, 32'h0, 1'b0);
      rchk("cfg erased", ADDR_CFG_DATA, 32'hffff_ffff, 32'h0, 1'b0);
      chk("pin_oe erased", 32'h0, {20'h0, pin_oe});
      end_of_test();
   end
endmodule // testbench
